// ==== hdl/cis_pkg.sv ====
// Constants, register map and state codes of the interrupt sequencer.
// Assumes a single core clock and an AHB-Lite register bus.
package cis_pkg;
  localparam int unsigned NUM_SRC    = 8;
  localparam logic [15:0] BOOT_START = 16'hF000;
  localparam logic [15:0] APP_BASE   = 16'h0000;
  localparam logic [15:0] SP_RESET   = 16'h10FF;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam logic [15:0] SP_STEP    = 16'h0002;
  localparam logic [2:0]  ENTRY_CYC  = 3'h4;
  localparam logic [2:0]  WAKE_CYC   = 3'h4;
  localparam logic [2:0]  JUMP_CYC   = 3'h3;
  localparam logic [2:0]  RET_CYC    = 3'h4;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_ENABLE = 8'h04;
  localparam logic [7:0]  OFF_FLAG   = 8'h08;
  localparam logic [7:0]  OFF_STATUS = 8'h0C;
  localparam logic [7:0]  OFF_SP     = 8'h10;
  // Field positions
  localparam int unsigned CTRL_GIE   = 0;
  localparam int unsigned CTRL_VSEL  = 1;
  localparam int unsigned STAT_STATE = 0;
  localparam int unsigned STAT_SHDW  = 4;
  localparam int unsigned STAT_PEND  = 5;
  localparam int unsigned STAT_IDX   = 8;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAKE  = 3'b001,
    ST_ENTRY = 3'b010,
    ST_JUMP  = 3'b011,
    ST_RET   = 3'b100
  } cis_state_t;
endpackage

// ==== hdl/cis_sequencer.sv ====
// Interrupt entry and return sequencer of the 8-bit core.
// Assumes pipeline pulses at instruction boundaries, a stack memory with
// one-cycle read latency, and an AHB-Lite master for the registers.
`timescale 1ns/1ns
`default_nettype none
module cis_sequencer #(
  parameter int unsigned           NSRC       = cis_pkg::NUM_SRC,
  parameter logic [NSRC-1:0]       LEVEL_MASK = '0
) (
  // Clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  // AHB-Lite slave
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic [31:0]         i_hwdata,
  input  wire logic                i_hready,
  output logic      [31:0]         o_hrdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  // Request sources
  input  wire logic [NSRC-1:0]     i_src_event,
  input  wire logic [NSRC-1:0]     i_src_level,
  // Fuse and lock settings
  input  wire logic                i_boot_reset_fuse,
  input  wire logic                i_app_boot_lock_setting,
  input  wire logic                i_boot_section_lock_setting,
  // Instruction pipeline
  input  wire logic                i_instr_done,
  input  wire logic                i_global_enable_instr,
  input  wire logic                i_global_disable_instr,
  input  wire logic                i_handler_return_instr,
  input  wire logic                i_sleeping,
  input  wire logic [15:0]         i_pc,
  output logic                     o_pc_load,
  output logic      [15:0]         o_pc_value,
  output logic                     o_handler_go,
  output logic                     o_busy,
  output logic                     o_gie,
  output logic      [15:0]         o_reset_vector,
  // Stack memory
  output logic                     o_stack_we,
  output logic                     o_stack_re,
  output logic      [15:0]         o_stack_addr,
  output logic      [7:0]          o_stack_wdata,
  input  wire logic [7:0]          i_stack_rdata
);
  import cis_pkg::*;

  localparam int unsigned IW = (NSRC > 1) ? $clog2(NSRC) : 1;

  cis_state_t        st_q;
  logic [2:0]        cnt_q;
  logic              gie_q;
  logic              shadow_q;
  logic              vsel_q;
  logic [NSRC-1:0]   en_q;
  logic [NSRC-1:0]   flag_q;
  logic [15:0]       sp_q;
  logic [15:0]       ret_pc_q;
  logic [15:0]       vec_q;
  logic [7:0]        pc_hi_q;
  logic [IW-1:0]     idx_q;
  logic              wr_q;
  logic [7:0]        addr_q;
  logic [IW-1:0]     idx_w;

  // Bus decode
  wire logic         ap_w      = i_hsel && i_htrans[1] && i_hready;
  wire logic         wr_ctrl   = wr_q && (addr_q == OFF_CTRL);
  wire logic         wr_en     = wr_q && (addr_q == OFF_ENABLE);
  wire logic         wr_flag   = wr_q && (addr_q == OFF_FLAG);
  wire logic         wr_sp     = wr_q && (addr_q == OFF_SP);

  // Request qualification
  wire logic [NSRC-1:0] pend_w = (flag_q & ~LEVEL_MASK)
                               | (i_src_level & LEVEL_MASK);
  wire logic [NSRC-1:0] req_w  = pend_w & en_q;
  wire logic         locked_w  =
      (i_app_boot_lock_setting && (i_pc < BOOT_START))
    || (i_boot_section_lock_setting && (i_pc >= BOOT_START));
  wire logic         idle_w    = (st_q == ST_IDLE);
  wire logic         bound_w   = i_instr_done || i_sleeping;
  wire logic         ctl_w     = i_instr_done
                               && (i_handler_return_instr
                                   || i_global_enable_instr);
  wire logic         accept    = idle_w && bound_w && (|req_w) && gie_q
                               && !shadow_q
                               && !i_global_disable_instr
                               && !locked_w && !ctl_w;
  wire logic         start_ret = idle_w && i_instr_done
                               && i_handler_return_instr;
  wire logic         ret_done  = (st_q == ST_RET)
                               && (cnt_q == RET_CYC - 3'h1);
  wire logic         sei_done  = idle_w && i_instr_done
                               && i_global_enable_instr;
  wire logic [15:0]  vbase_w   = vsel_q ? BOOT_START : APP_BASE;
  wire logic [15:0]  vec_w     = vbase_w
                               + VEC_STRIDE * (16'(idx_w) + 16'h0001);
  wire logic [15:0]  sp_dec_w  = sp_q - SP_STEP;

  // Read mux
  wire logic [31:0]  ctrl_rd   = (32'(gie_q) << CTRL_GIE)
                               | (32'(vsel_q) << CTRL_VSEL);
  wire logic [31:0]  stat_rd   = (32'(st_q) << STAT_STATE)
                               | (32'(shadow_q) << STAT_SHDW)
                               | (32'(|req_w) << STAT_PEND)
                               | (32'(idx_q) << STAT_IDX);
  wire logic [7:0]   ra_w      = i_haddr[7:0];
  wire logic [31:0]  rd_w      =
      (ra_w == OFF_CTRL)   ? ctrl_rd :
      (ra_w == OFF_ENABLE) ? 32'(en_q) :
      (ra_w == OFF_FLAG)   ? 32'(flag_q) :
      (ra_w == OFF_STATUS) ? stat_rd :
      (ra_w == OFF_SP)     ? {16'h0000, sp_q} : 32'h0000_0000;

  // Fixed priority: lowest index is lowest vector address
  always_comb begin
    idx_w = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req_w[i]) begin
        idx_w = IW'(i);
      end
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_q        <= 1'b0;
      addr_q      <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      wr_q        <= ap_w && i_hwrite;
      addr_q      <= i_haddr[7:0];
      if (ap_w && !i_hwrite) begin
        o_hrdata <= rd_w;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      en_q   <= '0;
      vsel_q <= 1'b0;
    end else begin
      if (wr_en) begin
        en_q <= i_hwdata[NSRC-1:0];
      end
      if (wr_ctrl) begin
        vsel_q <= i_hwdata[CTRL_VSEL];
      end
    end
  end

  // Sticky flags; a new event beats any clear
  for (genvar g = 0; g < NSRC; g++) begin : g_flag
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        flag_q[g] <= 1'b0;
      end else if (i_src_event[g]) begin
        flag_q[g] <= 1'b1;
      end else if (wr_flag && i_hwdata[g]) begin
        flag_q[g] <= 1'b0;
      end else if (accept && (idx_w == IW'(g))) begin
        flag_q[g] <= 1'b0;
      end
    end
  end

  // Global enable and one-instruction shadow
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gie_q    <= 1'b0;
      shadow_q <= 1'b0;
    end else begin
      if (ret_done) begin
        gie_q <= 1'b1;
      end else if (accept) begin
        gie_q <= 1'b0;
      end else if (i_instr_done && i_global_disable_instr) begin
        gie_q <= 1'b0;
      end else if (sei_done) begin
        gie_q <= 1'b1;
      end else if (wr_ctrl) begin
        gie_q <= i_hwdata[CTRL_GIE];
      end
      if (ret_done || sei_done) begin
        shadow_q <= 1'b1;
      end else if (i_instr_done) begin
        shadow_q <= 1'b0;
      end
    end
  end

  // Entry, jump and return sequencing; outputs one step per cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q          <= ST_IDLE;
      cnt_q         <= 3'h0;
      sp_q          <= SP_RESET;
      ret_pc_q      <= 16'h0000;
      vec_q         <= 16'h0000;
      pc_hi_q       <= 8'h00;
      idx_q         <= '0;
      o_stack_we    <= 1'b0;
      o_stack_re    <= 1'b0;
      o_stack_addr  <= 16'h0000;
      o_stack_wdata <= 8'h00;
      o_pc_load     <= 1'b0;
      o_pc_value    <= 16'h0000;
      o_handler_go  <= 1'b0;
    end else begin
      o_stack_we   <= 1'b0;
      o_stack_re   <= 1'b0;
      o_pc_load    <= 1'b0;
      o_handler_go <= 1'b0;
      cnt_q        <= cnt_q + 3'h1;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 3'h1;
          if (accept) begin
            ret_pc_q <= i_pc;
            vec_q    <= vec_w;
            idx_q    <= idx_w;
            if (i_sleeping) begin
              st_q <= ST_WAKE;
            end else begin
              st_q          <= ST_ENTRY;
              o_stack_we    <= 1'b1;
              o_stack_addr  <= sp_q;
              o_stack_wdata <= i_pc[7:0];
            end
          end else if (start_ret) begin
            st_q         <= ST_RET;
            o_stack_re   <= 1'b1;
            o_stack_addr <= sp_q + 16'h0001;
          end else if (wr_sp) begin
            sp_q <= i_hwdata[15:0];
          end
        end
        ST_WAKE: begin
          if (cnt_q == WAKE_CYC) begin
            st_q          <= ST_ENTRY;
            cnt_q         <= 3'h1;
            o_stack_we    <= 1'b1;
            o_stack_addr  <= sp_q;
            o_stack_wdata <= ret_pc_q[7:0];
          end
        end
        ST_ENTRY: begin
          if (cnt_q == 3'h1) begin
            o_stack_we    <= 1'b1;
            o_stack_addr  <= sp_q - 16'h0001;
            o_stack_wdata <= ret_pc_q[15:8];
          end else if (cnt_q == 3'h2) begin
            sp_q <= sp_dec_w;
          end else if (cnt_q == ENTRY_CYC - 3'h1) begin
            st_q       <= ST_JUMP;
            cnt_q      <= 3'h1;
            o_pc_load  <= 1'b1;
            o_pc_value <= vec_q;
          end
        end
        ST_JUMP: begin
          if (cnt_q == JUMP_CYC) begin
            st_q         <= ST_IDLE;
            o_handler_go <= 1'b1;
          end
        end
        ST_RET: begin
          if (cnt_q == 3'h1) begin
            o_stack_re   <= 1'b1;
            o_stack_addr <= sp_q + SP_STEP;
          end else if (cnt_q == 3'h2) begin
            pc_hi_q <= i_stack_rdata;
          end else if (ret_done) begin
            st_q       <= ST_IDLE;
            sp_q       <= sp_q + SP_STEP;
            o_pc_load  <= 1'b1;
            o_pc_value <= {pc_hi_q, i_stack_rdata};
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Core clock is used as is, no divider in the path
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_busy         <= 1'b0;
      o_gie          <= 1'b0;
      o_reset_vector <= APP_BASE;
    end else begin
      o_busy         <= !idle_w || accept || start_ret;
      o_gie          <= gie_q;
      o_reset_vector <= i_boot_reset_fuse ? BOOT_START : APP_BASE;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_entry;
    o_stack_we ##1 o_stack_we ##2 o_pc_load;
  endsequence
  sequence s_ret;
    o_stack_re ##1 o_stack_re ##2 (o_pc_load && gie_q);
  endsequence

  a_entry_len: assert property (accept && !i_sleeping |=> s_entry)
    else $error("entry sequence not four cycles");
  a_wake_len: assert property (accept && i_sleeping
      |-> ##8 o_pc_load)
    else $error("sleep entry not eight cycles");
  a_jump_len: assert property ($rose(st_q == ST_JUMP)
      |-> ##3 o_handler_go)
    else $error("vector jump not three cycles");
  a_ret_len: assert property (start_ret |=> s_ret)
    else $error("return sequence not four cycles");
  a_gie_clear: assert property (accept |=> !gie_q)
    else $error("global enable not cleared on entry");
  a_disable_now: assert property (i_instr_done && i_global_disable_instr
      |=> !gie_q && (st_q != ST_ENTRY) && (st_q != ST_WAKE))
    else $error("interrupt taken after global disable");
  a_enable_shadow: assert property (sei_done |=> !accept)
    else $error("interrupt served before next instruction");
  a_ret_shadow: assert property (ret_done |=> !accept)
    else $error("interrupt served right after return");
  a_flag_hold: assert property (|i_src_event
      |=> (flag_q & $past(i_src_event)) == $past(i_src_event))
    else $error("flag event lost");
  a_sp_push: assert property (accept && !i_sleeping
      |-> ##3 sp_q == $past(sp_q, 3) - SP_STEP)
    else $error("stack pointer not lowered by two");
  a_prio_low: assert property (accept
      |-> (req_w & ((NSRC'(1) << idx_w) - NSRC'(1))) == '0)
    else $error("lower vector left waiting");
endmodule
`default_nettype wire

// ==== dv/cis_stack_mem.sv ====
// Stack memory model on the far side of the interrupt sequencer.
// Assumes byte writes and a read answered in the cycle after the request.
`timescale 1ns/1ns
`default_nettype none
module cis_stack_mem (
  // Clock
  input  wire logic        i_core_clk,
  // Stack port
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] store [0:65535];
  initial o_rdata = 8'h00;
  always @(posedge i_core_clk) begin
    if (i_we) begin
      store[i_addr] <= i_wdata;
    end
    // Toggle outside a read so stale bytes never pass as valid
    if (i_re) begin
      o_rdata <= store[i_addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench of the interrupt sequencer with a reference model.
// Assumes the sequencer package and the stack memory model are compiled.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("MISMATCH %0t %s", $time, m); \
    end \
  end
module tb_top;
  import cis_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, pc_load, go, busy, gie, swe, sre;
  logic [NUM_SRC-1:0] ev = '0, lvl = '0;
  logic fuse = 1'b1, lock_a = 1'b0, lock_b = 1'b0, done = 1'b0;
  logic en_i = 1'b0, dis_i = 1'b0, ret_i = 1'b0, sleeping = 1'b0;
  logic [15:0] pc = '0, pc_value, rvec, saddr;
  logic [7:0] swdata, srdata;
  int fail_count = 0, checks = 0, m_sp, n, g, wr_n = 0;
  logic [7:0] m_flags = '0, m_en = '0;
  logic m_vsel = 1'b0;
  logic [31:0] q;
  logic [15:0] stk[$];
  always #4 clk = ~clk;
  // Stack bytes written, to see that nothing beyond the return address goes
  always @(posedge clk) if (swe === 1'b1) wr_n++;
  cis_sequencer #(.LEVEL_MASK(8'h80)) dut (.i_core_clk(clk), .i_rst(rst),
    .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_src_event(ev),
    .i_src_level(lvl), .i_boot_reset_fuse(fuse),
    .i_app_boot_lock_setting(lock_a), .i_boot_section_lock_setting(lock_b),
    .i_instr_done(done), .i_global_enable_instr(en_i),
    .i_global_disable_instr(dis_i), .i_handler_return_instr(ret_i),
    .i_sleeping(sleeping), .i_pc(pc), .o_pc_load(pc_load),
    .o_pc_value(pc_value), .o_handler_go(go), .o_busy(busy), .o_gie(gie),
    .o_reset_vector(rvec), .o_stack_we(swe), .o_stack_re(sre),
    .o_stack_addr(saddr), .o_stack_wdata(swdata), .i_stack_rdata(srdata));
  cis_stack_mem u_mem (.i_core_clk(clk), .i_we(swe), .i_re(sre),
    .i_addr(saddr), .i_wdata(swdata), .o_rdata(srdata));
  function automatic int pick();
    for (int k = 0; k < NUM_SRC; k++) begin
      if ((m_flags[k] | lvl[k]) & m_en[k]) return k;
    end
    return 0;
  endfunction
  function automatic logic [15:0] exp_vec(input int i);
    return (m_vsel ? BOOT_START : APP_BASE) + 16'(2 * (i + 1));
  endfunction
  // Single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    `CHK(hresp, 1'b0, "bus response")
  endtask
  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
    m_flags = m_flags | m;
  endtask
  // One boundary; n counts cycles to the load, g cycles on to the jump end
  task automatic fire(input logic e, input logic d, input logic r,
                      input logic s);
    n = 0;
    g = 0;
    if (s) sleeping <= 1'b1;
    else done <= 1'b1;
    en_i <= e;
    dis_i <= d;
    ret_i <= r;
    @(posedge clk);
    {done, sleeping, en_i, dis_i, ret_i} <= 5'b00000;
    for (int k = 1; k <= 12 && n == 0; k++) begin
      @(negedge clk);
      if (pc_load === 1'b1) n = k;
    end
    for (int k = 1; k <= 6 && n != 0 && g == 0; k++) begin
      @(negedge clk);
      if (go === 1'b1) g = k;
    end
    @(posedge clk);
  endtask
  task automatic entry(input logic s);
    int i;
    int w;
    logic [15:0] p;
    p = 16'($urandom_range(32'hEFFF));
    i = pick();
    pc <= p;
    w = wr_n;
    fire(1'b0, 1'b0, 1'b0, s);
    `CHK(n, s ? 8 : 4, "entry latency")
    `CHK(wr_n - w, 2, "bytes pushed")
    `CHK(pc_value, exp_vec(i), "vector")
    `CHK(g, 3, "jump length")
    `CHK(u_mem.store[16'(m_sp)], p[7:0], "low byte")
    `CHK(u_mem.store[16'(m_sp - 1)], p[15:8], "high byte")
    m_sp -= 2;
    stk.push_back(p);
    m_flags[i] = 1'b0;
    bus(1'b0, OFF_SP, '0);
    `CHK(q, 32'(m_sp), "sp after push")
    bus(1'b0, OFF_FLAG, '0);
    `CHK(q, {24'h000000, m_flags}, "flag clear")
    `CHK(gie, 1'b0, "enable on entry")
  endtask
  task automatic leave();
    logic [15:0] p;
    p = stk.pop_back();
    fire(1'b0, 1'b0, 1'b1, 1'b0);
    `CHK(n, 4, "return latency")
    `CHK(pc_value, p, "return address")
    m_sp += 2;
    bus(1'b0, OFF_SP, '0);
    `CHK(q, 32'(m_sp), "sp after pop")
    `CHK(gie, 1'b1, "enable on return")
  endtask
  task automatic refused(input logic e, input logic d);
    fire(e, d, 1'b0, 1'b0);
    `CHK(n, 0, "refused boundary")
  endtask
  task automatic wrap_up();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #160000;
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(95));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(rvec, BOOT_START, "boot reset vector")
    fuse <= 1'b0;
    bus(1'b0, OFF_SP, '0);
    `CHK(q, {16'h0000, SP_RESET}, "sp reset")
    bus(1'b0, 8'h14, '0);
    `CHK(q, 32'h00000000, "unmapped read")
    `CHK(rvec, APP_BASE, "app reset vector")
    bus(1'b1, OFF_SP, 32'h00001080);
    m_sp = 32'h1080;
    pulse(8'h08);
    refused(1'b0, 1'b0);
    pulse(8'h40);
    bus(1'b1, OFF_FLAG, 32'h00000000);
    bus(1'b0, OFF_FLAG, '0);
    `CHK(q, 32'h00000048, "held flags")
    bus(1'b1, OFF_FLAG, 32'h00000040);
    m_flags[6] = 1'b0;
    bus(1'b0, OFF_FLAG, '0);
    `CHK(q, 32'h00000008, "one clears")
    bus(1'b1, OFF_ENABLE, 32'h00000028);
    m_en = 8'h28;
    bus(1'b1, OFF_CTRL, 32'h00000001);
    pulse(8'h20);
    `CHK(busy, 1'b0, "waits for boundary")
    entry(1'b0);
    bus(1'b1, OFF_CTRL, 32'h00000001);
    entry(1'b0);
    leave();
    leave();
    pulse(8'h08);
    refused(1'b0, 1'b0);
    entry(1'b0);
    pulse(8'h20);
    leave();
    refused(1'b0, 1'b0);
    entry(1'b0);
    leave();
    bus(1'b1, OFF_CTRL, 32'h00000000);
    refused(1'b0, 1'b0);
    pulse(8'h08);
    refused(1'b1, 1'b0);
    `CHK(gie, 1'b1, "enable instruction")
    refused(1'b0, 1'b0);
    entry(1'b0);
    leave();
    refused(1'b0, 1'b0);
    pulse(8'h20);
    refused(1'b0, 1'b1);
    `CHK(gie, 1'b0, "disable instruction")
    bus(1'b1, OFF_CTRL, 32'h00000001);
    entry(1'b0);
    leave();
    refused(1'b0, 1'b0);
    pulse(8'h08);
    lock_a <= 1'b1;
    refused(1'b0, 1'b0);
    lock_a <= 1'b0;
    lock_b <= 1'b1;
    pc <= 16'hF100;
    refused(1'b0, 1'b0);
    entry(1'b0);
    lock_b <= 1'b0;
    leave();
    bus(1'b1, OFF_CTRL, 32'h00000003);
    m_vsel = 1'b1;
    bus(1'b1, OFF_ENABLE, 32'h000000FF);
    m_en = 8'hFF;
    for (int k = 0; k < 4; k++) begin
      refused(1'b0, 1'b0);
      pulse(8'($urandom_range(127, 1)));
      entry(k == 3);
      leave();
    end
    // Level source: served while present, not after it has gone
    bus(1'b1, OFF_FLAG, 32'h000000FF);
    m_flags = '0;
    lvl <= 8'h80;
    refused(1'b0, 1'b0);
    entry(1'b0);
    lvl <= '0;
    leave();
    refused(1'b0, 1'b0);
    refused(1'b0, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
